// file: verilog/plms_supervisor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// paper low conditioning, paper motion latch, half-inch strobe and
// format tape read sequencing
module plms_supervisor #(
  parameter int unsigned TAPE_CH = plms_pkg::TAPE_CH_STD  // tape channels
) (
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               low_switch_closed_i, // 1 = paper present
  input  wire logic               motion_sensor_i,     // disc optical level
  input  wire logic               feed_start_i,        // pulse, feed begins
  input  wire logic               motor_step_i,        // pulse, one step
  input  wire logic               lpi_eight_i,         // lpi switch level
  input  wire logic [TAPE_CH-1:0] tape_holes_i,        // tape sensor
  input  wire logic               tape_read_i,         // pulse, read request
  output logic                    paper_low_n_o,       // active low signal
  output logic                    low_lamp_o,          // panel indicator
  output logic                    host_paper_low_o,    // to host, high
  output logic [plms_pkg::PORT_W-1:0] port_twelve_o,   // polled input port
  output logic                    half_inch_strobe_o,  // pulse per 24 steps
  output logic [TAPE_CH-1:0]      tape_line_o,         // presented line
  output logic                    tape_valid_o,        // pulse, line ready
  output logic                    tape_advance_o       // pulse, sprocket
);

  // only the two documented reader widths are served
  if (TAPE_CH != plms_pkg::TAPE_CH_STD && TAPE_CH != plms_pkg::TAPE_CH_OPT)
    $error("TAPE_CH must be 8 or 12");

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [2:0] {
    PLMS_T_IDLE = 3'b001,  // no read pending
    PLMS_T_WAIT = 3'b010,  // waiting for half-inch strobe
    PLMS_T_SHOW = 3'b100   // present line
  } plms_tape_t;

  logic        low_reg,    low_next;     // conditioned paper low
  logic        low_n_reg,  low_n_next;   // active-low copy for the pin
  logic        motion_reg, motion_next;  // motion latch
  logic [4:0]  step_reg,   step_next;    // steps within half inch
  logic        strobe_reg, strobe_next;  // half-inch strobe
  plms_tape_t  tape_reg,   tape_next;    // tape sequencer
  logic [TAPE_CH-1:0] line_reg, line_next; // latched tape line
  logic        valid_reg,  valid_next;   // tape line pulse
  logic        adv_reg,    adv_next;     // sprocket pulse
  logic        motion_rise;              // sensor positive edge

  ////////////////////////////////////////////////////////////////////////////
  // motion sensor edge; slot-to-no-slot gives the positive edge
  plms_edge u_motion_edge (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .level_i   (motion_sensor_i),
    .rise_o    (motion_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // paper low and motion latch next values
  always_comb begin
    low_next = ~low_switch_closed_i;
    low_n_next = low_switch_closed_i;
    motion_next = motion_reg;
    // clear at feed start, but an edge in the same cycle still sets it
    if (feed_start_i) begin
      motion_next = 1'b0;
    end
    if (motion_rise) begin
      motion_next = 1'b1;
    end
    // paper low forces the latch set so the last form feeds without jam
    if (low_reg) begin
      motion_next = 1'b1;
    end
  end

  // paper low and motion registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_reg    <= 1'b0;
      low_n_reg  <= 1'b1;  // pin idles high: no paper low
      motion_reg <= plms_pkg::MOTION_RST;
    end else begin
      low_reg    <= low_next;
      low_n_reg  <= low_n_next;
      motion_reg <= motion_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half-inch strobe from motor step count
  always_comb begin
    step_next   = step_reg;
    strobe_next = 1'b0;
    if (motor_step_i) begin
      if (step_reg == 5'(plms_pkg::STEPS_PER_HALF - 1)) begin
        step_next   = plms_pkg::STEP_CNT_RST;
        strobe_next = 1'b1;
      end else begin
        step_next = step_reg + 5'h01;
      end
    end
  end

  // strobe registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_reg   <= plms_pkg::STEP_CNT_RST;
      strobe_reg <= 1'b0;
    end else begin
      step_reg   <= step_next;
      strobe_reg <= strobe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tape reader: one line per read, synced to the half-inch strobe
  always_comb begin
    tape_next  = tape_reg;
    line_next  = line_reg;
    valid_next = 1'b0;
    adv_next   = 1'b0;
    case (tape_reg)
      PLMS_T_IDLE: begin
        if (tape_read_i) begin
          tape_next = PLMS_T_WAIT;
        end
      end
      PLMS_T_WAIT: begin
        // wait for sprocket alignment before sampling holes
        if (strobe_reg) begin
          tape_next = PLMS_T_SHOW;
        end
      end
      PLMS_T_SHOW: begin
        line_next  = tape_holes_i;
        valid_next = 1'b1;
        adv_next   = 1'b1;
        tape_next  = PLMS_T_IDLE;
      end
      default: begin
        tape_next = PLMS_T_IDLE;
      end
    endcase
  end

  // tape registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tape_reg  <= PLMS_T_IDLE;
      line_reg  <= '0;
      valid_reg <= 1'b0;
      adv_reg   <= 1'b0;
    end else begin
      tape_reg  <= tape_next;
      line_reg  <= line_next;
      valid_reg <= valid_next;
      adv_reg   <= adv_next;
    end
  end

  // lpi switch sampling is the controller's job; just present it
  logic lpi_reg;  // registered lpi level
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lpi_reg <= 1'b0;
    end else begin
      lpi_reg <= lpi_eight_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  // own flop rather than an inverter after low_reg: no gate on the pin
  assign paper_low_n_o    = low_n_reg;
  assign low_lamp_o       = low_reg;
  assign host_paper_low_o = low_reg;
  always_comb begin
    port_twelve_o = '0;
    port_twelve_o[plms_pkg::BIT_LOW]    = low_reg;
    port_twelve_o[plms_pkg::BIT_MOTION] = motion_reg;
    port_twelve_o[plms_pkg::BIT_LPI]    = lpi_reg;
  end
  assign half_inch_strobe_o = strobe_reg;
  assign tape_line_o        = line_reg;
  assign tape_valid_o       = valid_reg;
  assign tape_advance_o     = adv_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // switch open shows paper low on every output one cycle later
  chk_low_to_port: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !low_switch_closed_i |=> port_twelve_o[5] && !paper_low_n_o
      && host_paper_low_o && low_lamp_o)
    else $error("paper low not shown");
  // clear direction too, so a stuck port bit or host line is caught
  chk_low_bit_tracks: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    low_switch_closed_i |=> !port_twelve_o[5] && paper_low_n_o
      && !host_paper_low_o && !low_lamp_o)
    else $error("paper low shown with paper present");
  // a positive sensor edge always lands in the latch
  chk_edge_sets: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    motion_sensor_i && !$past(motion_sensor_i) |=> port_twelve_o[8])
    else $error("motion edge missed");
  // the motion bit never rises without an edge or paper low
  chk_motion_bit: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(port_twelve_o[8]) |-> $past(motion_rise) || $past(low_reg))
    else $error("motion bit set without cause");
  // paper low keeps the latch set from its second cycle on
  chk_low_holds: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    low_reg [*2] |-> port_twelve_o[8])
    else $error("paper low did not hold latch");
  // a plain feed start empties the latch
  chk_feed_clears: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    feed_start_i && !motion_rise && !low_reg |=> !port_twelve_o[8])
    else $error("latch not cleared at feed");
  // strobe is a single-cycle pulse
  chk_strobe_gap: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    half_inch_strobe_o |=> !half_inch_strobe_o)
    else $error("strobe longer than one cycle");
  // strobe only follows the last step of a half inch
  chk_strobe_count: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    half_inch_strobe_o |-> $past(motor_step_i)
      && $past(step_reg) == 5'(plms_pkg::STEPS_PER_HALF - 1))
    else $error("strobe not on last step of half inch");
  // line shown two cycles after the strobe, with the sprocket pulse
  chk_tape_sync: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    tape_valid_o |-> $past(strobe_reg, 2) && tape_advance_o)
    else $error("tape read not strobe synced");
  // the presented line only moves with its valid pulse
  chk_tape_hold: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $stable(tape_line_o) || tape_valid_o)
    else $error("tape line changed without a read");
endmodule // plms_supervisor

// file: verilog/plms_pkg.sv
// Functional notes
// - switch open asserts low signal and lamp
// - paper low on bit five, host high
// - first motion rising edge sets latch
// - set latch drives bit eight high
// - paper low holds motion latch set
// - tape reader advances one line per read
// - half-inch strobe every twenty-four steps
package plms_pkg;
  localparam int unsigned STEPS_PER_INCH   = 48;  // motor steps per inch
  localparam int unsigned STEPS_PER_HALF   = 24;  // steps per half-inch strobe
  localparam int unsigned BIT_LOW          = 5;   // port bit, paper low
  localparam int unsigned BIT_MOTION       = 8;   // port bit, motion
  localparam int unsigned BIT_LPI          = 9;   // port bit, lpi switch
  localparam int unsigned TAPE_CH_STD      = 8;   // standard tape channels
  localparam int unsigned TAPE_CH_OPT      = 12;  // optional tape channels
  localparam int unsigned PORT_W           = 16;  // input port width
  localparam logic        MOTION_RST       = 1'b0; // motion latch reset
  localparam logic [4:0]  STEP_CNT_RST     = 5'h00; // step counter reset
endpackage

// file: verilog/plms_edge.sv
`timescale 1ns/1ps
// rising edge detector on an input already synchronous to clk_i
module plms_edge (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic level_i,
  output logic      rise_o
);
  logic last_reg;  // previous sample
  logic last_next;

  // next value is just the current level
  always_comb begin
    last_next = level_i;
  end

  // register the sample
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= last_next;
    end
  end

  assign rise_o = level_i & ~last_reg;
endmodule // plms_edge

// file: verif/plms_ctrl_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// behavioural control program: one line feed per go_i, paper low
// run-out and jam handling; alarm, stop and go are only seen between
// feeds, so a pulse given mid-feed is lost
module plms_ctrl_model #(
  parameter int unsigned EXTRA_INCHES = 5  // run-out after paper low
) (
  input  wire logic        clk_i,
  input  wire logic        go_i,          // start one line feed
  input  wire logic        alarm_reset_i, // operator alarm reset
  input  wire logic        stop_i,        // pulse, printer enters stop
  input  wire logic        strobe_i,      // half-inch strobe
  input  wire logic [15:0] port_i,        // polled input port
  output logic             feed_start_o,  // pulse, feed begins
  output logic             motor_step_o,  // pulse, one step
  output logic             jam_o,         // jam indication
  output logic             paper_out_o,   // stopped at top of form
  output logic             busy_o         // feed in progress
);
  logic lpi_sel     = 1'b0;  // lpi used by feeds, taken at stop
  logic low_seen    = 1'b0;  // paper low found by a poll
  int   lines_left  = 0;     // run-out lines still to go
  int   strobe_cnt  = 0;     // strobes seen so far
  int   strobe_mark = 0;     // strobe_cnt at feed start
  initial begin
    feed_start_o = 1'b0;
    motor_step_o = 1'b0;
    jam_o        = 1'b0;
    paper_out_o  = 1'b0;
    busy_o       = 1'b0;
  end
  // strobe counter; here a half-inch strobe stands for top of form
  always @(posedge clk_i) begin
    if (strobe_i === 1'b1) begin
      strobe_cnt <= strobe_cnt + 1;
    end
  end
  // idle housekeeping and feed sequence in one process, one driver each
  always @(posedge clk_i) begin
    if (alarm_reset_i) begin
      jam_o <= 1'b0;
    end
    if (stop_i) begin
      lpi_sel <= port_i[plms_pkg::BIT_LPI];
    end
    // new forms loaded: paper low gone, run mode allowed again
    if (port_i[plms_pkg::BIT_LOW] === 1'b0) begin
      low_seen    <= 1'b0;
      paper_out_o <= 1'b0;
    end
    if (go_i && !paper_out_o) begin
      busy_o       <= 1'b1;
      feed_start_o <= 1'b1;
      strobe_mark  = strobe_cnt;
      @(posedge clk_i) feed_start_o <= 1'b0;
      repeat (lpi_sel ? 6 : 8) begin
        @(posedge clk_i) motor_step_o <= 1'b1;
        @(posedge clk_i) motor_step_o <= 1'b0;
      end
      repeat (3) @(posedge clk_i);
      if (port_i[plms_pkg::BIT_MOTION] !== 1'b1) begin
        jam_o <= 1'b1;
      end
      // one paper low poll per line advanced
      if (port_i[plms_pkg::BIT_LOW] === 1'b1) begin
        if (!low_seen) begin
          low_seen   <= 1'b1;
          lines_left <= int'(EXTRA_INCHES) * (lpi_sel ? 8 : 6);
        end else if (lines_left != 0) begin
          lines_left <= lines_left - 1;
        end else if (strobe_cnt != strobe_mark) begin
          paper_out_o <= 1'b1;
        end
      end
      busy_o <= 1'b0;
    end
  end
endmodule // plms_ctrl_model

// file: verif/paper_low_and_motion_supervisor_test.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module paper_low_and_motion_supervisor_test;
  logic        clk_i     = 1'b0;  // 10 MHz
  logic        reset_n_i = 1'b0;  // async, active low
  logic        sw        = 1'b1;  // paper present
  logic        mot       = 1'b0;  // motion sensor
  logic        lpi       = 1'b0;  // lpi switch
  logic        go        = 1'b0;  // feed request to model
  logic        alarm     = 1'b0;  // alarm reset
  logic        trd       = 1'b0;  // tape read request
  logic        stop      = 1'b0;  // printer enters stop
  logic [7:0]  holes     = 8'ha5; // tape pattern
  logic        fs, stp, jam, busy, low_n, lamp, host, strb, tv, tadv, pout;
  logic [15:0] port;
  logic [7:0]  tline, got_line;
  int          fail_count = 0, compares = 0, cyc = 0;
  int          strobes = 0, reads = 0, advances = 0, starts = 0, mark = 0;
  // paper low run-out: five inches at six lines per inch
  localparam int RUN_OUT_LINES = 5 * 6;
  // rows: switch, lpi, {low_n, lamp, host}, port
  logic [20:0] tbl [4] = '{21'h140000, 21'h1c0200, 21'h0b0320,
                           21'h140100};
  plms_supervisor dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .low_switch_closed_i(sw), .motion_sensor_i(mot), .feed_start_i(fs),
    .motor_step_i(stp), .lpi_eight_i(lpi), .tape_holes_i(holes),
    .tape_read_i(trd), .paper_low_n_o(low_n), .low_lamp_o(lamp),
    .host_paper_low_o(host), .port_twelve_o(port),
    .half_inch_strobe_o(strb), .tape_line_o(tline), .tape_valid_o(tv),
    .tape_advance_o(tadv));
  plms_ctrl_model ctrl_u (.clk_i(clk_i), .go_i(go), .alarm_reset_i(alarm),
    .stop_i(stop), .strobe_i(strb), .port_i(port), .feed_start_o(fs),
    .motor_step_o(stp), .jam_o(jam), .paper_out_o(pout), .busy_o(busy));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // pulse watchers; one-cycle pulses are easy to miss by polling
  // sampled mid-cycle, where the registered outputs have settled
  always @(negedge clk_i) begin
    cyc++;
    if (strb === 1'b1) strobes++;
    if (tadv === 1'b1) advances++;
    if (fs === 1'b1) starts++;
    if (tv === 1'b1) begin
      reads++;
      got_line = tline;
    end
    // about five times the length of the whole run
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  // one line feed, optional motion pulse part way through
  task automatic feed(input logic move);
    int n;
    n = 0;
    go = 1'b1;
    @(negedge clk_i) go = 1'b0;
    repeat (3) @(negedge clk_i);
    mot = move;
    @(negedge clk_i) mot = 1'b0;
    while (busy === 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    foreach (tbl[i]) begin
      {sw, lpi} = tbl[i][20:19];
      repeat (3) @(negedge clk_i);
      chk({13'h0, low_n, lamp, host}, {13'h0, tbl[i][18:16]}, "low");
      chk(port, tbl[i][15:0], "port");
    end
    feed(1'b1);
    chk({15'h0, jam}, 16'h0000, "jam despite motion");
    feed(1'b0);
    chk({15'h0, jam}, 16'h0001, "stale motion bit");
    alarm = 1'b1;
    @(negedge clk_i) alarm = 1'b0;
    sw = 1'b0;
    feed(1'b0);
    chk({15'h0, jam}, 16'h0000, "false jam at paper low");
    reset_n_i = 1'b0;
    @(negedge clk_i);
    chk({13'h0, low_n, lamp, host}, 16'h0004, "reset lamp");
    chk(port, 16'h0000, "reset port");
    sw = 1'b1;
    reset_n_i = 1'b1;
    strobes = 0;
    feed(1'b1);
    feed(1'b1);
    chk(16'(strobes), 16'h0000, "early strobe");
    trd = 1'b1;
    @(negedge clk_i) trd = 1'b0;
    feed(1'b1);
    repeat (4) @(negedge clk_i);
    chk(16'(strobes), 16'h0001, "strobe at 24 steps");
    chk(16'(reads), 16'h0001, "one tape line");
    chk({8'h00, got_line}, {8'h00, holes}, "tape line");
    chk(16'(advances), 16'h0001, "one sprocket advance");
    // eight lpi takes effect only once stop samples the switch
    lpi = 1'b1;
    @(negedge clk_i) stop = 1'b1;
    @(negedge clk_i) stop = 1'b0;
    strobes = 0;
    repeat (3) feed(1'b1);
    chk(16'(strobes), 16'h0000, "strobe before 24 steps at 8 lpi");
    feed(1'b1);
    chk(16'(strobes), 16'h0001, "strobe at 24 steps at 8 lpi");
    lpi = 1'b0;
    @(negedge clk_i) stop = 1'b1;
    @(negedge clk_i) stop = 1'b0;
    // paper low: detecting line, run-out lines, one line with no strobe
    sw = 1'b0;
    repeat (RUN_OUT_LINES + 2) feed(1'b0);
    chk({14'h0, jam, pout}, 16'h0000, "stopped before run-out");
    feed(1'b0);
    chk({15'h0, pout}, 16'h0001, "no stop at top of form");
    mark = starts;
    feed(1'b1);
    chk(16'(starts - mark), 16'h0000, "feed while paper out");
    sw = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({15'h0, pout}, 16'h0000, "paper out after reload");
    feed(1'b1);
    chk(16'(starts - mark), 16'h0001, "no feed after reload");
    chk({15'h0, jam}, 16'h0000, "jam after reload");
    tally_and_finish();
  end
endmodule // paper_low_and_motion_supervisor_test
